// *** core/sbs_defs.svh ***
// constants for the burst memory input-capture block
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH
`define SBS_ADDR_W 18
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_DATA_W 36
`define SBS_BURST_W 2
`define SBS_FIFO_DEPTH 8
`define SBS_CMD_W 59
`endif

// *** core/sbs_pkg.sv ***
// types for the burst memory input-capture block
`include "sbs_defs.svh"
package sbs_pkg;
	typedef enum logic [1:0] {SBS_IDLE, SBS_READ, SBS_WRITE} sbs_acc_e;
endpackage : sbs_pkg

// *** core/sbs_fifo.sv ***
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sbs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} sbs_fifo_s;
	sbs_fifo_s st_q, st_d;
	logic push, pop;
	assign in_ready = (st_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st_q.cnt != '0);
	assign out_data = st_q.mem[st_q.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.mem[st_q.wr] = in_data;
			st_d.wr = st_q.wr + 1'b1;
		end
		if (pop)
			st_d.rd = st_q.rd + 1'b1;
		st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule : sbs_fifo
`default_nettype wire

// *** core/sbs_input_ctrl.sv ***
// input capture and command qualification of a pipelined burst memory
//
// Behaviour
// - every synchronous input is registered on each rising edge and acted on two edges later only if the clock qualifier was low.
// - with the qualifier high no access state changes; the input pipeline still shifts and the command fifo still drains.
// - the address including its two burst bits is captured on a qualified edge to pick a location.
// - a lane is written only when its active-low select and the write strobe were both low at the load; burst steps reuse them.
// - each lane select governs only its own data lane and parity bit.
// - the write strobe is sampled on every edge but only acted on at a load on a qualified edge.
// - advance/load high on a qualified edge steps the burst counter only while selected with an access in progress.
// - advance/load low on a qualified edge while selected loads the presented address as a new access.
// - selection needs first select low, second high and third low; anything else deselects.
// - the second select is active high and combines with the two active-low selects.
// - a high qualifier does not deselect; access state, selected and the data drivers just hold.
// - data and parity drivers are off during write data, the first clock after deselect and while deselected.
// - the order strap picks interleaved when high and linear when low, held constant.
`timescale 1ns/100ps
`default_nettype none
`include "sbs_defs.svh"
module sbs_input_ctrl
	import sbs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clock_qualifier_n,
	input wire logic chip_select_first_n,
	input wire logic chip_select_second,
	input wire logic chip_select_third_n,
	input wire logic advance_or_load_sel,
	input wire logic write_strobe_n,
	input wire logic [`SBS_ADDR_W-1:0] addr_in,
	input wire logic lane_a_write_sel_n,
	input wire logic lane_b_write_sel_n,
	input wire logic lane_c_write_sel_n,
	input wire logic lane_d_write_sel_n,
	input wire logic burst_order_strap,
	input wire logic output_enable_n,
	input wire logic [`SBS_DATA_W-1:0] data_lanes_in,
	output logic [`SBS_DATA_W-1:0] data_lanes_out,
	output logic [`SBS_DATA_W-1:0] data_lanes_oe,
	output logic cmd_valid,
	input wire logic cmd_ready,
	output logic cmd_write,
	output logic [`SBS_ADDR_W-1:0] cmd_addr,
	output logic [`SBS_LANES-1:0] cmd_lane_we,
	output logic [`SBS_DATA_W-1:0] cmd_wdata,
	input wire logic [`SBS_DATA_W-1:0] read_data,
	output logic selected,
	output logic stalled
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] qual_n_s;
		logic [1:0] ce1_s;
		logic [1:0] ce2_s;
		logic [1:0] ce3_s;
		logic [1:0] adv_s;
		logic [1:0] we_n_s;
		logic [1:0][`SBS_ADDR_W-1:0] addr_s;
		logic [1:0][`SBS_LANES-1:0] bw_n_s;
		logic [1:0] oe_n_s;
		logic [1:0][`SBS_DATA_W-1:0] din_s;
		logic [1:0] mode_s;
		sbs_acc_e acc;
		sbs_acc_e prev_acc;
		logic first_after_desel;
		logic interleave;
		logic [`SBS_ADDR_W-1:0] base_addr;
		logic [`SBS_BURST_W-1:0] burst_cnt;
		logic [`SBS_LANES-1:0] lanes_n;
		logic wr_pend;
		logic [`SBS_ADDR_W-1:0] wr_addr;
		logic [`SBS_LANES-1:0] wr_lanes_n;
		logic [`SBS_DATA_W-1:0] dout;
		logic drive;
	} sbs_st_s;
	sbs_st_s st_q, st_d;

	logic [`SBS_CMD_W-1:0] fifo_in, fifo_out;
	logic fifo_in_valid, fifo_in_ready;
	logic qual, sel_now, load, advance, is_write;
	logic [`SBS_BURST_W-1:0] next_cnt, burst_bits;
	logic [`SBS_ADDR_W-1:0] acc_addr;
	logic [`SBS_LANES-1:0] acc_lanes_n;

	// ------------------------------------------------------------
	// qualification and access decode
	// ------------------------------------------------------------
	always_comb begin
		qual = !st_q.qual_n_s[1] && fifo_in_ready;
		sel_now = !st_q.ce1_s[1] && st_q.ce2_s[1] && !st_q.ce3_s[1];
		load = qual && !st_q.adv_s[1] && sel_now;
		advance = qual && st_q.adv_s[1] && sel_now && (st_q.acc != SBS_IDLE);
		next_cnt = st_q.burst_cnt + 1'b1;
		burst_bits = st_q.interleave ? (st_q.base_addr[`SBS_BURST_W-1:0] ^ next_cnt)
			: (st_q.base_addr[`SBS_BURST_W-1:0] + next_cnt);
		acc_addr = load ? st_q.addr_s[1]
			: {st_q.base_addr[`SBS_ADDR_W-1:`SBS_BURST_W], burst_bits};
		acc_lanes_n = load ? st_q.bw_n_s[1] : st_q.lanes_n;
		is_write = load ? !st_q.we_n_s[1] : (st_q.acc == SBS_WRITE);
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.qual_n_s = {st_q.qual_n_s[0], clock_qualifier_n};
		st_d.ce1_s = {st_q.ce1_s[0], chip_select_first_n};
		st_d.ce2_s = {st_q.ce2_s[0], chip_select_second};
		st_d.ce3_s = {st_q.ce3_s[0], chip_select_third_n};
		st_d.adv_s = {st_q.adv_s[0], advance_or_load_sel};
		st_d.we_n_s = {st_q.we_n_s[0], write_strobe_n};
		st_d.addr_s = {st_q.addr_s[0], addr_in};
		st_d.bw_n_s = {st_q.bw_n_s[0], {lane_d_write_sel_n, lane_c_write_sel_n,
			lane_b_write_sel_n, lane_a_write_sel_n}};
		st_d.oe_n_s = {st_q.oe_n_s[0], output_enable_n};
		st_d.din_s = {st_q.din_s[0], data_lanes_in};
		st_d.mode_s = {st_q.mode_s[0], burst_order_strap};
		fifo_in_valid = 1'b0;
		if (qual) begin
			st_d.prev_acc = st_q.acc;
			st_d.wr_pend = 1'b0;
			if (load) begin
				st_d.base_addr = st_q.addr_s[1];
				st_d.burst_cnt = '0;
				st_d.lanes_n = st_q.bw_n_s[1];
				st_d.interleave = st_q.mode_s[1];
				st_d.acc = is_write ? SBS_WRITE : SBS_READ;
			end else if (advance) begin
				st_d.burst_cnt = next_cnt;
			end else if (!sel_now || !st_q.adv_s[1]) begin
				st_d.acc = SBS_IDLE;
			end
			st_d.first_after_desel = (st_q.acc == SBS_IDLE) && (load || advance);
			if (st_q.wr_pend)
				fifo_in_valid = 1'b1;
			if ((load || advance) && is_write) begin
				st_d.wr_pend = 1'b1;
				st_d.wr_addr = acc_addr;
				st_d.wr_lanes_n = acc_lanes_n;
			end else if ((load || advance) && !is_write) begin
				fifo_in_valid = !st_q.wr_pend;
				st_d.dout = read_data;
			end
			st_d.drive = (load || advance) && !is_write && !st_q.oe_n_s[1]
				&& !(st_q.acc == SBS_IDLE);
		end
	end

	// write commands carry data captured one qualified edge after their address
	assign fifo_in = st_q.wr_pend
		? {1'b1, st_q.wr_addr, ~st_q.wr_lanes_n, st_q.din_s[1]}
		: {1'b0, acc_addr, {`SBS_LANES{1'b0}}, {`SBS_DATA_W{1'b0}}};

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_q <= '0;
			st_q.qual_n_s <= 2'h3;
			st_q.ce1_s <= 2'h3;
			st_q.we_n_s <= 2'h3;
			st_q.bw_n_s <= '1;
			st_q.oe_n_s <= 2'h3;
			st_q.mode_s <= 2'h3;
			st_q.acc <= SBS_IDLE;
			st_q.prev_acc <= SBS_IDLE;
			st_q.lanes_n <= '1;
			st_q.wr_lanes_n <= '1;
			st_q.interleave <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// command buffer
	// ------------------------------------------------------------
	sbs_fifo #(.WIDTH(`SBS_CMD_W), .DEPTH(`SBS_FIFO_DEPTH)) u_cmd_fifo (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(cmd_valid),
		.out_ready(cmd_ready),
		.out_data(fifo_out)
	);

	assign cmd_write = fifo_out[`SBS_CMD_W-1];
	assign cmd_addr = fifo_out[`SBS_CMD_W-2 -: `SBS_ADDR_W];
	assign cmd_lane_we = fifo_out[`SBS_DATA_W +: `SBS_LANES];
	assign cmd_wdata = fifo_out[`SBS_DATA_W-1:0];
	assign data_lanes_out = st_q.dout;
	assign data_lanes_oe = {`SBS_DATA_W{st_q.drive && !st_q.first_after_desel}};
	assign selected = (st_q.acc != SBS_IDLE);
	assign stalled = !fifo_in_ready;
endmodule : sbs_input_ctrl
`default_nettype wire

// *** testbench/sbs_monitor.sv ***
// checker on the input-capture ports
`timescale 1ns/100ps
`default_nettype none
module sbs_monitor (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clock_qualifier_n,
	input wire logic chip_select_first_n,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [17:0] cmd_addr,
	input wire logic [3:0] cmd_lane_we,
	input wire logic [35:0] data_lanes_oe,
	input wire logic selected,
	input wire logic stalled
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	chk_full_valid: assert property (stalled |-> cmd_valid) else $error("full, no valid");
	chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=>
		cmd_valid && $stable({cmd_write, cmd_addr, cmd_lane_we})) else $error("head moved");
	chk_read_lanes: assert property (cmd_valid && !cmd_write |-> cmd_lane_we == 4'h0) else $error("read lanes");
	chk_oe_desel: assert property (!selected |-> data_lanes_oe == 36'h0) else $error("oe idle");
	chk_hold_sel: assert property (clock_qualifier_n [*4] |=> $stable(selected)) else $error("sel moved");
	chk_hold_oe: assert property (clock_qualifier_n [*4] |=> $stable(data_lanes_oe)) else $error("oe moved");
	chk_hold_push: assert property (clock_qualifier_n [*4] ##0 !cmd_ready |=> $stable(cmd_valid))
		else $error("push in hold");
	chk_desel_cs: assert property ((!clock_qualifier_n && !stalled && chip_select_first_n) [*4] |=> !selected)
		else $error("not deselected");
endmodule : sbs_monitor
bind sbs_input_ctrl sbs_monitor u_mon (.clk_sys, .rst_b, .clock_qualifier_n, .chip_select_first_n, .cmd_valid,
	.cmd_ready, .cmd_write, .cmd_addr, .cmd_lane_we, .data_lanes_oe, .selected, .stalled);
`default_nettype wire

// *** testbench/sbs_core_model.sv ***
// command consumer standing behind the fifo
`timescale 1ns/100ps
`default_nettype none
module sbs_core_model (
	input wire logic clk_sys,
	input wire logic hold,
	output logic cmd_ready,
	output logic [35:0] read_data
);
	// read data never repeats, so a stale capture shows
	initial read_data = 36'h0;
	always @(posedge clk_sys) read_data <= #1 read_data + 36'h10001;
	assign cmd_ready = !hold;
endmodule : sbs_core_model
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the burst memory input capture
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk_sys = 0, rst_b = 0, qn = 0, c1 = 1, c2 = 0, c3 = 1, adv = 0, wen = 1, strap = 0, hold = 0;
	logic cmd_valid, cmd_ready, cmd_write, selected, stalled;
	logic [17:0] addr = 0, cmd_addr;
	logic [3:0] ln = 4'hF, cmd_lane_we;
	logic [35:0] din = 0, rd, cmd_wdata, dout, oe, rd_cap = 0;
	logic oen = 0;
	logic [1:0] qn_p = 2'h3;
	logic [58:0] exp_q[$], e;
	int n_fail = 0, compares = 0, seed = 12206, k, n_oe = 0;
	always #25 clk_sys = ~clk_sys;
	sbs_input_ctrl dut (.clk_sys, .rst_b, .clock_qualifier_n(qn), .chip_select_first_n(c1), .chip_select_second(c2),
		.chip_select_third_n(c3), .advance_or_load_sel(adv), .write_strobe_n(wen), .addr_in(addr),
		.lane_a_write_sel_n(ln[0]), .lane_b_write_sel_n(ln[1]), .lane_c_write_sel_n(ln[2]),
		.lane_d_write_sel_n(ln[3]), .burst_order_strap(strap), .output_enable_n(oen), .data_lanes_in(din),
		.data_lanes_out(dout), .data_lanes_oe(oe), .cmd_valid, .cmd_ready, .cmd_write, .cmd_addr, .cmd_lane_we,
		.cmd_wdata, .read_data(rd), .selected, .stalled);
	sbs_core_model u_core (.clk_sys, .hold, .cmd_ready, .read_data(rd));
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task automatic stop_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test
	task automatic op(input logic [2:0] cs, input logic a, w, input logic [17:0] ad, input logic [3:0] l,
		input logic [35:0] d);
		{c1, c2, c3, adv, wen, addr, ln, din} = {cs, a, w, ad, l, d};
		@(posedge clk_sys);
		#1;
	endtask : op
	task automatic rdo(input logic [17:0] ad);
		exp_q.push_back({1'b0, ad, 4'h0, 36'h0});
		op(3'b010, 0, 1, ad, 4'hF, ~din);
	endtask : rdo
	task automatic wro(input logic [17:0] ad, input logic [3:0] l, input logic [35:0] d);
		exp_q.push_back({1'b1, ad, ~l, d});
		op(3'b010, 0, 0, ad, l, ~d);
		op(3'b101, 0, 1, ~ad, 4'hF, d);
	endtask : wro
	task automatic idle(input int n);
		repeat (n) op(3'b101, 0, 1, ~addr, 4'hF, ~din);
	endtask : idle
	task automatic drain;
		for (int i = 0; i < 60 && exp_q.size() > 0; i++) @(posedge clk_sys);
		#1;
		chk(exp_q.size() == 0, "commands missing");
		if (exp_q.size() != 0) stop_test;
	endtask : drain
	always @(posedge clk_sys) begin
		if (rst_b && cmd_valid === 1'b1 && cmd_ready) begin
			if (exp_q.size() == 0) begin
				chk(1'b0, "unexpected command");
			end else begin
				e = exp_q.pop_front();
				chk({cmd_write, cmd_addr, cmd_lane_we} === e[58:36] && (!e[58] || cmd_wdata === e[35:0]), "cmd");
			end
		end
		// read data must be the value taken at the last qualified edge
		if (rst_b && oe === '1) begin
			n_oe++;
			chk(dout === rd_cap, "read data");
		end
		if (!qn_p[1] && stalled === 1'b0)
			rd_cap = rd;
		qn_p = {qn_p[0], qn};
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		#1;
		rst_b = 1;
		idle(1);
		for (k = 0; k < 6; k++) rdo(18'($random(seed)));
		for (k = 0; k < 16; k++) wro(18'($random(seed)), k[3:0], 36'($random(seed)));
		for (k = 0; k < 8; k++) if (k != 2) op(k[2:0], 0, 1, 18'($random(seed)), 4'hF, ~din);
		idle(4);
		chk(selected === 1'b0, "still selected");
		rdo(18'h2A5A5);
		qn = 1;
		hold = 1;
		repeat (5) op(3'b010, 0, 0, 18'($random(seed)), 4'h0, ~din);
		chk(selected === 1'b1, "hold deselected");
		qn = 0;
		hold = 0;
		idle(4);
		drain;
		n_oe = 0;
		for (k = 0; k < 2; k++) begin
			strap = k[0];
			oen = k[0];
			idle(3);
			rdo({16'h1234, 2'b01});
			exp_q.push_back({1'b0, 16'h1234, k[0] ? 2'b00 : 2'b10, 4'h0, 36'h0});
			op(3'b010, 1, 0, 18'h0, 4'h0, ~din);
		end
		// write burst: the step keeps direction and lanes of the load
		exp_q.push_back({1'b1, 16'h5A5A, 2'b10, 4'hA, 36'h123456789});
		exp_q.push_back({1'b1, 16'h5A5A, 2'b11, 4'hA, 36'hFEDCBA987});
		op(3'b010, 0, 0, {16'h5A5A, 2'b10}, 4'h5, 36'h0);
		op(3'b010, 1, 1, 18'h0, 4'hF, 36'h123456789);
		op(3'b101, 0, 1, 18'h0, 4'hF, 36'hFEDCBA987);
		idle(3);
		drain;
		chk(n_oe == 1, "drive count");
		oen = 0;
		hold = 1;
		for (k = 0; k < 8; k++) rdo(18'(k + 9));
		idle(4);
		chk(stalled === 1'b1, "not full");
		hold = 0;
		drain;
		stop_test;
	end
endmodule : testbench
`default_nettype wire
